//--- symbol_counter_clock_irq.sv
`timescale 1ns/100ps
module symbol_counter_clock_irq (
	input  wire logic                                   pclk,
	input  wire logic                                   presetn,
	input  wire logic [symbol_counter_pkg::ADDR_W-1:0]  paddr,
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [symbol_counter_pkg::DATA_W-1:0]  pwdata,
	output logic      [symbol_counter_pkg::DATA_W-1:0]  prdata,
	output logic                                        pready,
	output logic                                        pslverr,
	input  wire logic                                   crystal_clock_tick,
	input  wire logic                                   realtime_oscillator_input,
	input  wire logic                                   external_counter_clock_pin,
	input  wire logic                                   transceiver_sleep,
	input  wire logic [2:0]                             compare_match,
	input  wire logic [symbol_counter_pkg::FLAG_W-1:0]  irq_ack,
	output logic      [symbol_counter_pkg::FLAG_W-1:0]  counter_irq_request,
	output logic      [31:0]                            counter_value
);
	import symbol_counter_pkg::*;

	symbol_tick_if tk ();

	logic                 pready_reg;
	logic                 pslverr_reg;
	logic [DATA_W-1:0]    prdata_reg;
	logic                 clock_select_reg;
	logic [2:0]           divider_reg;
	logic                 ext_enable_reg;
	logic                 backoff_en_reg;
	logic [FLAG_W-1:0]    mask_reg;
	logic [FLAG_W-1:0]    mask_next;
	logic [FLAG_W-1:0]    status_reg;
	logic [FLAG_W-1:0]    status_next;
	logic [FLAG_W-1:0]    events;
	logic [FLAG_W-1:0]    irq_req_reg;
	logic [31:0]          count_reg;
	logic [31:8]          stage_reg;
	logic [7:0]           stage_low_reg;
	logic [31:0]          staged_value;
	logic                 pending_reg;
	logic [4:0]           slot_reg;
	logic                 setup_phase;
	logic                 wr_en;
	logic                 mapped;
	logic [7:0]           read_byte;
	logic                 tick;
	logic                 wrap_event;
	logic                 slot_event;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == byte_addr(idx));
	endfunction : hit

	symbol_tick_gen u_tick (
		.pclk                       (pclk),
		.presetn                    (presetn),
		.crystal_clock_tick         (crystal_clock_tick),
		.realtime_oscillator_input  (realtime_oscillator_input),
		.external_counter_clock_pin (external_counter_clock_pin),
		.tk                         (tk.gen)
	);

	assign tk.divider    = divider_reg;
	assign tk.rtc_select = clock_select_reg;
	assign tk.ext_enable = ext_enable_reg;
	assign tk.sleep      = transceiver_sleep;
	assign tick          = tk.symbol_tick;

	// ==========================================
	// APB slave: one wait state, answer registered
	assign setup_phase = psel && penable && !pready_reg;
	assign wr_en       = psel && penable && pready_reg && pwrite;
	assign mapped      = hit(paddr, IDX_CONTROL_FIRST) || hit(paddr, IDX_CONTROL_SECOND)
		|| hit(paddr, IDX_BUSY_STATUS) || hit(paddr, IDX_IRQ_MASK)
		|| hit(paddr, IDX_IRQ_STATUS) || hit(paddr, IDX_COUNT_LL)
		|| hit(paddr, IDX_COUNT_LH) || hit(paddr, IDX_COUNT_HL)
		|| hit(paddr, IDX_COUNT_HH);

	// Reserved bits read as zero
	always_comb begin
		read_byte = 8'h00;
		if (hit(paddr, IDX_CONTROL_FIRST)) begin
			read_byte[SEL_BIT] = clock_select_reg;
		end else if (hit(paddr, IDX_CONTROL_SECOND)) begin
			read_byte = {3'h0, divider_reg, ext_enable_reg, backoff_en_reg};
		end else if (hit(paddr, IDX_BUSY_STATUS)) begin
			read_byte[BUSY_BIT] = pending_reg;
		end else if (hit(paddr, IDX_IRQ_MASK)) begin
			read_byte = {3'h0, mask_reg};
		end else if (hit(paddr, IDX_IRQ_STATUS)) begin
			read_byte = {3'h0, status_reg};
		end else if (hit(paddr, IDX_COUNT_LL)) begin
			read_byte = count_reg[7:0];
		end else if (hit(paddr, IDX_COUNT_LH)) begin
			read_byte = count_reg[15:8];
		end else if (hit(paddr, IDX_COUNT_HL)) begin
			read_byte = count_reg[23:16];
		end else if (hit(paddr, IDX_COUNT_HH)) begin
			read_byte = count_reg[31:24];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= setup_phase;
			pslverr_reg <= setup_phase && !mapped;
			if (setup_phase && !pwrite) begin
				prdata_reg <= {24'h00_0000, read_byte};
			end
		end
	end

	// ==========================================
	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_select_reg <= 1'b0;
			divider_reg      <= DIV_RESET;
			ext_enable_reg   <= 1'b0;
			backoff_en_reg   <= 1'b0;
		end else if (wr_en && hit(paddr, IDX_CONTROL_FIRST)) begin
			clock_select_reg <= pwdata[SEL_BIT];
		end else if (wr_en && hit(paddr, IDX_CONTROL_SECOND)) begin
			divider_reg    <= pwdata[DIV_LSB +: 3];
			ext_enable_reg <= pwdata[EXT_BIT];
			backoff_en_reg <= pwdata[BACKOFF_BIT];
		end
	end

	// ==========================================
	// Counter with staged write; the load waits for the next symbol tick,
	// which is why the busy flag can stand for a whole symbol period
	assign wrap_event   = tick && !pending_reg && (count_reg == 32'hFFFF_FFFF);
	assign staged_value = {stage_reg, stage_low_reg};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_reg     <= 24'h00_0000;
			stage_low_reg <= 8'h00;
		end else if (wr_en && hit(paddr, IDX_COUNT_LL)) begin
			stage_low_reg <= pwdata[7:0];
		end else if (wr_en && hit(paddr, IDX_COUNT_LH)) begin
			stage_reg[15:8] <= pwdata[7:0];
		end else if (wr_en && hit(paddr, IDX_COUNT_HL)) begin
			stage_reg[23:16] <= pwdata[7:0];
		end else if (wr_en && hit(paddr, IDX_COUNT_HH)) begin
			stage_reg[31:24] <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg   <= COUNT_RESET;
			pending_reg <= 1'b0;
		end else begin
			if (tick) begin
				count_reg   <= pending_reg ? staged_value : count_reg + 32'h1;
				pending_reg <= 1'b0;
			end
			// A new low-byte write keeps busy set over a load in the same cycle; that load still takes the old staged value
			if (wr_en && hit(paddr, IDX_COUNT_LL)) begin
				pending_reg <= 1'b1;
			end
		end
	end

	// ==========================================
	// Backoff slot counter, restarts from zero whenever disabled
	assign slot_event = backoff_en_reg && tick && (slot_reg == BACKOFF_SYMBOLS - 5'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_reg <= 5'h00;
		end else if (!backoff_en_reg) begin
			slot_reg <= 5'h00;
		end else if (tick) begin
			slot_reg <= slot_event ? 5'h00 : slot_reg + 5'h01;
		end
	end

	// ==========================================
	// Status and mask; a new event wins over any clear in the same cycle
	always_comb begin
		events               = FLAGS_RESET;
		events[FLAG_BACKOFF] = slot_event;
		events[FLAG_OVF]     = wrap_event;
		events[FLAG_CMP3]    = compare_match[2];
		events[FLAG_CMP2]    = compare_match[1];
		events[FLAG_CMP1]    = compare_match[0];
		status_next = status_reg & ~(irq_ack & mask_reg);
		if (wr_en && hit(paddr, IDX_IRQ_STATUS)) begin
			status_next = status_next & ~pwdata[FLAG_W-1:0];
		end
		status_next = status_next | events;
		mask_next   = mask_reg;
		if (wr_en && hit(paddr, IDX_IRQ_MASK)) begin
			mask_next = pwdata[FLAG_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg  <= FLAGS_RESET;
			mask_reg    <= FLAGS_RESET;
			irq_req_reg <= FLAGS_RESET;
		end else begin
			status_reg  <= status_next;
			mask_reg    <= mask_next;
			irq_req_reg <= status_next & mask_next;
		end
	end

	assign prdata              = prdata_reg;
	assign pready              = pready_reg;
	assign pslverr             = pslverr_reg;
	assign counter_irq_request = irq_req_reg;
	assign counter_value       = count_reg;

	// ==========================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_busy_set_write: assert property (
		wr_en && hit(paddr, IDX_COUNT_LL) |=> pending_reg)
		else $error("busy not set after low byte write");
	chk_busy_load_value: assert property (
		pending_reg && tick && !(wr_en && hit(paddr, IDX_COUNT_LL))
		|=> !pending_reg && count_reg == $past(staged_value))
		else $error("pending value not loaded or busy stuck");
	chk_overflow_flag: assert property (
		tick && !pending_reg && count_reg == 32'hFFFF_FFFF
		|=> status_reg[FLAG_OVF] && count_reg == 32'h0000_0000)
		else $error("wrap did not set overflow flag");
	chk_compare_flag: assert property (
		compare_match[2] |=> status_reg[FLAG_CMP3])
		else $error("compare unit 3 match lost");
	chk_write_one_clears: assert property (
		wr_en && hit(paddr, IDX_IRQ_STATUS) && pwdata[FLAG_CMP1] && !compare_match[0]
		|=> !status_reg[FLAG_CMP1])
		else $error("write one did not clear flag");
	chk_write_zero_keeps: assert property (
		wr_en && hit(paddr, IDX_IRQ_STATUS) && status_reg[FLAG_CMP3] && !pwdata[FLAG_CMP3]
		&& !(irq_ack[FLAG_CMP3] && mask_reg[FLAG_CMP3]) |=> status_reg[FLAG_CMP3])
		else $error("write zero cleared flag");
	chk_masked_silent: assert property (
		mask_reg == FLAGS_RESET && !(wr_en && hit(paddr, IDX_IRQ_MASK))
		|=> counter_irq_request == FLAGS_RESET)
		else $error("request raised while all masked");
	chk_enable_pending: assert property (
		wr_en && hit(paddr, IDX_IRQ_MASK) && pwdata[FLAG_CMP1] && status_reg[FLAG_CMP1]
		&& !irq_ack[FLAG_CMP1] |=> counter_irq_request[FLAG_CMP1])
		else $error("enable on set flag did not request");
	chk_ack_clears: assert property (
		irq_ack[FLAG_CMP1] && mask_reg[FLAG_CMP1] && !compare_match[0]
		|=> !status_reg[FLAG_CMP1] && !counter_irq_request[FLAG_CMP1])
		else $error("handler entry did not clear flag");
	chk_backoff_slot: assert property (
		backoff_en_reg && tick && slot_reg == 5'h13
		|=> status_reg[FLAG_BACKOFF] && slot_reg == 5'h00)
		else $error("backoff slot not flagged at twenty");

	cov_backoff_irq: cover property (slot_event && mask_reg[FLAG_BACKOFF]);
	cov_overflow: cover property (wrap_event);
	cov_busy_load: cover property (pending_reg && tick);
	cov_bad_address: cover property (setup_phase && !mapped);
endmodule : symbol_counter_clock_irq

//--- symbol_counter_pkg.sv
package symbol_counter_pkg;
	// ==========================================
	// Bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// ==========================================
	// Register indices, byte address is four times the index
	localparam logic [7:0] IDX_CONTROL_FIRST  = 8'hDC;
	localparam logic [7:0] IDX_CONTROL_SECOND = 8'hDD;
	localparam logic [7:0] IDX_BUSY_STATUS    = 8'hDE;
	localparam logic [7:0] IDX_IRQ_MASK       = 8'hDF;
	localparam logic [7:0] IDX_IRQ_STATUS     = 8'hE0;
	localparam logic [7:0] IDX_COUNT_LL       = 8'hE1;
	localparam logic [7:0] IDX_COUNT_LH       = 8'hE2;
	localparam logic [7:0] IDX_COUNT_HL       = 8'hE3;
	localparam logic [7:0] IDX_COUNT_HH       = 8'hE4;

	// ==========================================
	// Field positions
	localparam int unsigned SEL_BIT      = 4;
	localparam int unsigned DIV_LSB      = 2;
	localparam int unsigned EXT_BIT      = 1;
	localparam int unsigned BACKOFF_BIT  = 0;
	localparam int unsigned BUSY_BIT     = 0;
	localparam int unsigned FLAG_BACKOFF = 4;
	localparam int unsigned FLAG_OVF     = 3;
	localparam int unsigned FLAG_CMP3    = 2;
	localparam int unsigned FLAG_CMP2    = 1;
	localparam int unsigned FLAG_CMP1    = 0;
	localparam int unsigned FLAG_W       = 5;

	// ==========================================
	// Reset values and counts
	localparam logic [2:0]        DIV_RESET       = 3'h0;
	localparam logic [FLAG_W-1:0] FLAGS_RESET     = 5'h00;
	localparam logic [31:0]       COUNT_RESET     = 32'h0000_0000;
	localparam logic [4:0]        BACKOFF_SYMBOLS = 5'h14;
	localparam logic [7:0]        PRESCALE_TOP    = 8'hFF;

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		byte_addr = {2'h0, idx, 2'h0};
	endfunction : byte_addr
endpackage : symbol_counter_pkg

//--- symbol_tick_gen.sv
`timescale 1ns/100ps
module symbol_tick_gen (
	input  wire logic    pclk,
	input  wire logic    presetn,
	input  wire logic    crystal_clock_tick,
	input  wire logic    realtime_oscillator_input,
	input  wire logic    external_counter_clock_pin,
	symbol_tick_if.gen   tk
);
	import symbol_counter_pkg::*;

	logic [2:0] rtc_sync_reg;
	logic [2:0] ext_sync_reg;
	logic [7:0] prescale_reg;
	logic       tick_reg;
	logic       rtc_rise;
	logic       ext_rise;
	logic       xtal_pulse;
	logic [7:0] limit;

	// Code 7 is undefined; it behaves as the fastest setting
	function automatic logic [7:0] prescale_limit(input logic [2:0] code);
		prescale_limit = (code == 3'h7) ? (PRESCALE_TOP >> 6) : (PRESCALE_TOP >> code);
	endfunction : prescale_limit

	// ==========================================
	// Pin synchronisers; only stages two and three feed the edge detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rtc_sync_reg <= 3'h0;
			ext_sync_reg <= 3'h0;
		end else begin
			rtc_sync_reg <= {rtc_sync_reg[1:0], realtime_oscillator_input};
			ext_sync_reg <= {ext_sync_reg[1:0], external_counter_clock_pin};
		end
	end

	assign rtc_rise   = rtc_sync_reg[1] & ~rtc_sync_reg[2];
	assign ext_rise   = ext_sync_reg[1] & ~ext_sync_reg[2];
	assign limit      = prescale_limit(tk.divider);
	assign xtal_pulse = crystal_clock_tick && (prescale_reg >= limit);

	// ==========================================
	// Prescaler; >= keeps it safe when the code shrinks mid-count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_reg <= 8'h00;
		end else if (crystal_clock_tick) begin
			prescale_reg <= xtal_pulse ? 8'h00 : prescale_reg + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_reg <= 1'b0;
		end else if (tk.ext_enable) begin
			tick_reg <= ext_rise;
		end else if (tk.rtc_select || tk.sleep) begin
			tick_reg <= rtc_rise;
		end else begin
			tick_reg <= xtal_pulse;
		end
	end

	assign tk.symbol_tick = tick_reg;

	// ==========================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_prescale_tick: assert property (
		!tk.ext_enable && !tk.rtc_select && !tk.sleep && crystal_clock_tick
		&& prescale_reg == limit |=> tick_reg)
		else $error("prescaler end gave no tick");
	chk_sleep_rtc: assert property (
		!tk.ext_enable && tk.sleep && !rtc_rise |=> !tick_reg)
		else $error("tick in sleep without rtc edge");
	chk_ext_edge_once: assert property (
		tk.ext_enable && ext_rise |=> tick_reg ##1 !tick_reg)
		else $error("pin edge not counted once");
	chk_ext_override: assert property (
		tk.ext_enable && !ext_rise |=> !tick_reg)
		else $error("tick from other source under pin clock");
endmodule : symbol_tick_gen

//--- symbol_tick_if.sv
`timescale 1ns/100ps
interface symbol_tick_if;
	logic [2:0] divider;
	logic       rtc_select;
	logic       ext_enable;
	logic       sleep;
	logic       symbol_tick;

	modport gen (input divider, input rtc_select, input ext_enable, input sleep,
		output symbol_tick);
	modport user (output divider, output rtc_select, output ext_enable, output sleep,
		input symbol_tick);
endinterface : symbol_tick_if

//--- test_symbol_counter_clock_irq.sv
`timescale 1ns/100ps
module test_symbol_counter_clock_irq;
	import symbol_counter_pkg::*;

	logic                pclk;
	logic                presetn;
	logic [ADDR_W-1:0]   paddr;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [DATA_W-1:0]   pwdata;
	logic [DATA_W-1:0]   prdata;
	logic                pready;
	logic                pslverr;
	logic                crystal_clock_tick;
	logic                realtime_oscillator_input;
	logic                external_counter_clock_pin;
	logic                transceiver_sleep;
	logic [2:0]          compare_match;
	logic [FLAG_W-1:0]   irq_ack;
	logic [FLAG_W-1:0]   counter_irq_request;
	logic [31:0]         counter_value;
	logic                tick_en;
	int                  err_total;
	int                  checks_done;
	int                  cyc;

	symbol_counter_clock_irq dut (
		.pclk                       (pclk),
		.presetn                    (presetn),
		.paddr                      (paddr),
		.psel                       (psel),
		.penable                    (penable),
		.pwrite                     (pwrite),
		.pwdata                     (pwdata),
		.prdata                     (prdata),
		.pready                     (pready),
		.pslverr                    (pslverr),
		.crystal_clock_tick         (crystal_clock_tick),
		.realtime_oscillator_input  (realtime_oscillator_input),
		.external_counter_clock_pin (external_counter_clock_pin),
		.transceiver_sleep          (transceiver_sleep),
		.compare_match              (compare_match),
		.irq_ack                    (irq_ack),
		.counter_irq_request        (counter_irq_request),
		.counter_value              (counter_value)
	);

	always #25 pclk = ~pclk;

	// Transceiver clock modelled as one pulse per pclk cycle while enabled
	always @(posedge pclk) crystal_clock_tick <= tick_en;

	// ==========================================
	// Hang guard: all tests need well under this many cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end

	// ==========================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= {2'h0, idx, 2'h0};
		pwrite  <= wr;
		pwdata  <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// No answer time assumed; only the hang guard ends a lost answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] idx, output logic [31:0] r);
		logic e;
		apb(1'b0, idx, 8'h00, r, e);
	endtask : rd

	// Pins toggle far below a quarter of pclk
	task automatic pins(input int nr, input int ne);
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			realtime_oscillator_input  <= (i < nr);
			external_counter_clock_pin <= (i < ne);
			repeat (4) @(posedge pclk);
			realtime_oscillator_input  <= 1'b0;
			external_counter_clock_pin <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		repeat (8) @(posedge pclk);
	endtask : pins

	// ==========================================
	// Scenarios
	task automatic t_reset_values();
		logic [31:0] r;
		logic        e;
		rd(IDX_BUSY_STATUS, r);    check(r, 32'h0000_0000);
		rd(IDX_IRQ_MASK, r);       check(r, 32'h0000_0000);
		rd(IDX_IRQ_STATUS, r);     check(r, 32'h0000_0000);
		rd(IDX_CONTROL_SECOND, r); check(r, 32'h0000_0000);
		apb(1'b0, 8'h10, 8'h00, r, e);
		check({31'h0, e}, 32'h0000_0001);
		$display("test reset_values done");
	endtask : t_reset_values

	task automatic t_divider();
		logic [31:0] v;
		int          n;
		tick_en <= 1'b1;
		// Code 7 is undefined and runs as the fastest setting
		for (int code = 0; code < 8; code++) begin
			wr(IDX_CONTROL_SECOND, 8'(code << 2));
			// Skip the interval that straddles the divider change
			for (int k = 0; k < 3; k++) begin
				v = counter_value;
				n = 0;
				while (counter_value === v && n < 600) begin
					@(posedge pclk);
					n++;
				end
			end
			check(32'(n), (code == 7) ? 32'd4 : 32'(256 >> code));
		end
		$display("test divider done");
	endtask : t_divider

	task automatic t_sources();
		logic [31:0] v;
		logic [7:0]  sel [4] = '{8'h00, 8'h10, 8'h10, 8'h00};
		logic [7:0]  ext [4] = '{8'h18, 8'h18, 8'h1A, 8'h1A};
		logic        slp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		int          exp [4] = '{4, 4, 2, 2};
		tick_en <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			wr(IDX_CONTROL_FIRST, sel[m]);
			wr(IDX_CONTROL_SECOND, ext[m]);
			@(posedge pclk);
			transceiver_sleep <= slp[m];
			repeat (4) @(posedge pclk);
			v = counter_value;
			pins(4, 2);
			check(counter_value - v, 32'(exp[m]));
		end
		@(posedge pclk);
		transceiver_sleep <= 1'b0;
		wr(IDX_CONTROL_FIRST, 8'h00);
		$display("test sources done");
	endtask : t_sources

	task automatic t_load_overflow();
		logic [31:0] r;
		int          n;
		tick_en <= 1'b0;
		wr(IDX_CONTROL_SECOND, 8'h18);
		wr(IDX_IRQ_STATUS, 8'h1F);
		wr(IDX_COUNT_LH, 8'hFF);
		wr(IDX_COUNT_HL, 8'hFF);
		wr(IDX_COUNT_HH, 8'hFF);
		wr(IDX_COUNT_LL, 8'hFE);
		rd(IDX_BUSY_STATUS, r);    check(r, 32'h0000_0001);
		tick_en <= 1'b1;
		n = 0;
		while (counter_value !== 32'hFFFF_FFFE && n < 50) begin
			@(posedge pclk);
			n++;
		end
		check(counter_value, 32'hFFFF_FFFE);
		n = 0;
		while (counter_value !== 32'h0000_0000 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		tick_en <= 1'b0;
		rd(IDX_BUSY_STATUS, r);    check(r, 32'h0000_0000);
		rd(IDX_IRQ_STATUS, r);     check(r, 32'h0000_0008);
		check({27'h0, counter_irq_request}, 32'h0000_0000);
		wr(IDX_IRQ_STATUS, 8'h08);
		$display("test load_overflow done");
	endtask : t_load_overflow

	task automatic t_flags();
		logic [31:0] r;
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			compare_match <= 3'(1 << i);
			@(posedge pclk);
			compare_match <= 3'h0;
			rd(IDX_IRQ_STATUS, r); check(r, 32'((2 << i) - 1));
		end
		wr(IDX_IRQ_STATUS, 8'h02);
		rd(IDX_IRQ_STATUS, r);     check(r, 32'h0000_0005);
		wr(IDX_IRQ_MASK, 8'h01);
		@(posedge pclk);
		check({27'h0, counter_irq_request}, 32'h0000_0001);
		@(posedge pclk);
		irq_ack <= 5'h05;
		@(posedge pclk);
		irq_ack <= 5'h00;
		rd(IDX_IRQ_STATUS, r);     check(r, 32'h0000_0004);
		check({27'h0, counter_irq_request}, 32'h0000_0000);
		wr(IDX_IRQ_MASK, 8'h1F);
		rd(IDX_IRQ_MASK, r);       check(r, 32'h0000_001F);
		check({27'h0, counter_irq_request}, 32'h0000_0004);
		wr(IDX_IRQ_MASK, 8'h00);
		wr(IDX_IRQ_STATUS, 8'h1F);
		$display("test flags done");
	endtask : t_flags

	task automatic t_backoff();
		logic [31:0] v;
		int          n;
		wr(IDX_IRQ_MASK, 8'h10);
		wr(IDX_CONTROL_SECOND, 8'h19);
		tick_en <= 1'b1;
		n = 0;
		while (counter_irq_request[4] !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		v = counter_value;
		irq_ack <= 5'h10;
		@(posedge pclk);
		irq_ack <= 5'h00;
		repeat (2) @(posedge pclk);
		check({27'h0, counter_irq_request}, 32'h0000_0000);
		n = 0;
		while (counter_irq_request[4] !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		check(counter_value - v, 32'd20);
		wr(IDX_CONTROL_SECOND, 8'h18);
		wr(IDX_IRQ_MASK, 8'h00);
		$display("test backoff done");
	endtask : t_backoff

	// ==========================================
	// Closing report and main sequence
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		paddr = '0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = '0;
		tick_en = 1'b0;
		crystal_clock_tick = 1'b0;
		realtime_oscillator_input = 1'b0;
		external_counter_clock_pin = 1'b0;
		transceiver_sleep = 1'b0;
		compare_match = 3'h0;
		irq_ack = 5'h00;
		err_total = 0;
		checks_done = 0;
		cyc = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_values();
		t_divider();
		t_sources();
		t_load_overflow();
		t_flags();
		t_backoff();
		finish_test();
	end
endmodule : test_symbol_counter_clock_irq
